// ### inc/hscb_consts.svh
/*
  Constants of the high-speed counter bank: channel counts, limits, register
  offsets, field positions, error codes and timing counts.
  Assumes a 50 MHz core clock and inclusion by its bare name.
*/
// How it works
// - Sixteen fast inputs; counter n quadrature A is input 2n, B is 2n+1.
// - Counters 0 to 3 take their trigger from fast inputs 8 to 11.
// - Direction 0 counts up, 1 counts down, in single-phase mode only.
// - Enable 1 counts pulses; enable 0 stops and holds the value.
// - Counting up, counters 0-3 stop at maximum, 4-7 wrap to minimum.
// - Counting down, counters 0-3 stop at minimum, 4-7 wrap to maximum.
// - Linear counting treats both 32-bit extremes as invalid counts.
// - Ring counting on counters 0-3 may use both extremes as bounds.
// - Each count reads back as a signed 32-bit number.
// - Frequency is reported in hertz, measured in hardware on inputs 0-3.
// - Counters 0 and 1 in quadrature report the A-phase frequency only.
// - Loading a new program never clears any count.
// - Fast inputs count signals up to 200 kHz.
// - Only inputs 0-7 raise event strobes, at most 3 kHz each.
// - A select value 0 to 7 picks the counter that commands act on.
// - Valid is 1 while outputs are valid; error flag with error code.
`ifndef HSCB_CONSTS_SVH
`define HSCB_CONSTS_SVH

`define HSCB_NUM_CH        8
`define HSCB_NUM_IN        16
`define HSCB_TRIG_BASE     8
`define HSCB_FREQ_INPUTS   4
`define HSCB_SAT_CHANNELS  4
`define HSCB_EVENT_INPUTS  8

`define HSCB_CNT_MAX       32'sh7FFFFFFF
`define HSCB_CNT_MIN       32'sh80000000

`define HSCB_OFS_SELECT    8'h00
`define HSCB_OFS_CONFIG    8'h04
`define HSCB_OFS_RING_LO   8'h08
`define HSCB_OFS_RING_HI   8'h0C
`define HSCB_OFS_COUNT     8'h10
`define HSCB_OFS_FREQ      8'h14
`define HSCB_OFS_STATUS    8'h18

`define HSCB_CFG_ENABLE    0
`define HSCB_CFG_DIR       1
`define HSCB_CFG_QUAD      2
`define HSCB_CFG_RING      3
`define HSCB_CFG_TRIG      4
`define HSCB_CFG_ERRCLR    8
`define HSCB_ST_VALID      0
`define HSCB_ST_ERROR      1

`define HSCB_ERR_NONE      16'h0000
`define HSCB_ERR_LIMIT     16'h0001
`define HSCB_ERR_RING      16'h0002
`define HSCB_ERR_QUAD      16'h0003

`define HSCB_CLK_HZ        50000000
`define HSCB_GATE_TIME_MS  1000
`define HSCB_GATE_CYCLES   ((`HSCB_CLK_HZ / 1000) * `HSCB_GATE_TIME_MS)
`define HSCB_MAX_IN_KHZ    200
`define HSCB_IN_MIN_CYCLES (`HSCB_CLK_HZ / (`HSCB_MAX_IN_KHZ * 1000))
`define HSCB_EVENT_MAX_HZ  3000
`define HSCB_EVENT_GAP     ((`HSCB_CLK_HZ + `HSCB_EVENT_MAX_HZ - 1) / `HSCB_EVENT_MAX_HZ)

`endif

// ### inc/hscb_pkg.sv
/*
  Types of the high-speed counter bank.
  Assumes nothing of its surroundings.
*/
package hscb_pkg;
    typedef logic signed [31:0] hscb_count_type;
    typedef struct packed {
        logic trig_en;
        logic ring;
        logic quad;
        logic dir;
        logic enable;
    } hscb_cfg_type;
endpackage

// ### core/hscb_chan.sv
/*
  One counter channel: single-phase or quadrature decode, saturating or
  wrapping limits, ring range and trigger zeroing.
  Assumes inputs synchronous to clock and settings held by the bank.
*/
`timescale 1ns/1ps
`include "hscb_consts.svh"
module hscb_chan #(
    parameter logic SATURATE = 1'b1
) (
    input  wire logic                   clock,      // Core clock
    input  wire logic                   rst,        // Async reset
    input  wire logic                   ce,         // Clock enable
    input  wire logic                   a_in,       // A phase or pulse
    input  wire logic                   b_in,       // B phase
    input  wire logic                   trig_in,    // External trigger
    input  wire hscb_pkg::hscb_cfg_type cfg,        // Channel settings
    input  wire logic                   err_clear,  // Clear sticky error
    input  wire hscb_pkg::hscb_count_type ring_lo,  // Ring lower bound
    input  wire hscb_pkg::hscb_count_type ring_hi,  // Ring upper bound
    output hscb_pkg::hscb_count_type    count_r,    // Current count
    output logic                        err_r,      // Error flag
    output logic [15:0]                 err_code_r  // Error code
);
    logic a_q;
    logic b_q;
    logic t_q;
    logic quad_bad_r;
    logic step_up;
    logic step_dn;
    logic illegal;
    logic at_limit;

    // Next count for one step in either direction
    function automatic hscb_pkg::hscb_count_type next_cnt(
        input hscb_pkg::hscb_count_type c,
        input logic up,
        input logic ring,
        input hscb_pkg::hscb_count_type lo,
        input hscb_pkg::hscb_count_type hi
    );
        if (ring) begin
            if (up) next_cnt = (c == hi) ? lo : c + 32'sh00000001;
            else    next_cnt = (c == lo) ? hi : c - 32'sh00000001;
        end else if (up) begin
            next_cnt = (c == `HSCB_CNT_MAX) ? (SATURATE ? c : `HSCB_CNT_MIN)
                                            : c + 32'sh00000001;
        end else begin
            next_cnt = (c == `HSCB_CNT_MIN) ? (SATURATE ? c : `HSCB_CNT_MAX)
                                            : c - 32'sh00000001;
        end
    endfunction

    assign illegal = cfg.quad & (a_in ^ a_q) & (b_in ^ b_q);
    assign step_up = cfg.quad ? (((a_in ^ a_q) ^ (b_in ^ b_q)) & ~(a_q ^ b_in))
                              : (a_in & ~a_q & ~cfg.dir);
    assign step_dn = cfg.quad ? (((a_in ^ a_q) ^ (b_in ^ b_q)) & (a_q ^ b_in))
                              : (a_in & ~a_q & cfg.dir);
    assign at_limit = ~cfg.ring & ((count_r == `HSCB_CNT_MAX) | (count_r == `HSCB_CNT_MIN));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            t_q <= 1'b0;
        end else if (ce) begin
            a_q <= a_in;
            b_q <= b_in;
            t_q <= trig_in;
        end
    end

    // Count cleared by reset or an enabled trigger edge, never by settings writes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_r <= 32'sh00000000;
        end else if (ce && cfg.enable) begin
            if (cfg.trig_en && trig_in && !t_q) begin
                count_r <= 32'sh00000000;
            end else if (step_up || step_dn) begin
                count_r <= next_cnt(count_r, step_up, cfg.ring, ring_lo, ring_hi);
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            quad_bad_r <= 1'b0;
            err_r      <= 1'b0;
            err_code_r <= `HSCB_ERR_NONE;
        end else if (ce) begin
            // Set wins over clear
            if (cfg.enable && illegal) quad_bad_r <= 1'b1;
            else if (err_clear)        quad_bad_r <= 1'b0;
            err_r      <= quad_bad_r | at_limit;
            err_code_r <= quad_bad_r ? `HSCB_ERR_QUAD : (at_limit ? `HSCB_ERR_LIMIT : `HSCB_ERR_NONE);
        end
    end

    property p_hold_off;
        @(posedge clock) disable iff (rst) (!cfg.enable) |=> $stable(count_r);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("count moved while disabled");

    property p_sat_top;
        @(posedge clock) disable iff (rst)
            (ce && cfg.enable && !cfg.ring && step_up && !(cfg.trig_en && trig_in && !t_q)
             && count_r == `HSCB_CNT_MAX)
            |=> (count_r == (SATURATE ? `HSCB_CNT_MAX : `HSCB_CNT_MIN));
    endproperty
    a_sat_top: assert property (p_sat_top) else $error("wrong action at upper limit");

    property p_sat_bot;
        @(posedge clock) disable iff (rst)
            (ce && cfg.enable && !cfg.ring && step_dn && !(cfg.trig_en && trig_in && !t_q)
             && count_r == `HSCB_CNT_MIN)
            |=> (count_r == (SATURATE ? `HSCB_CNT_MIN : `HSCB_CNT_MAX));
    endproperty
    a_sat_bot: assert property (p_sat_bot) else $error("wrong action at lower limit");

    property p_ring_wrap;
        @(posedge clock) disable iff (rst)
            (ce && cfg.enable && cfg.ring && step_up && !(cfg.trig_en && trig_in && !t_q)
             && count_r == ring_hi) |=> (count_r == $past(ring_lo));
    endproperty
    a_ring_wrap: assert property (p_ring_wrap) else $error("ring did not wrap to lower bound");

    property p_quad_step;
        @(posedge clock) disable iff (rst)
            (ce && cfg.enable && cfg.quad && !cfg.ring && !cfg.trig_en && step_up
             && count_r != `HSCB_CNT_MAX) |=> (count_r == $past(count_r) + 32'sh00000001);
    endproperty
    a_quad_step: assert property (p_quad_step) else $error("quadrature step not one");

    property p_quad_err;
        @(posedge clock) disable iff (rst)
            (ce && cfg.enable && illegal) ##1 ce |=> (err_r && err_code_r == `HSCB_ERR_QUAD);
    endproperty
    a_quad_err: assert property (p_quad_err) else $error("illegal transition not flagged");
endmodule

// ### core/hscb_top.sv
/*
  Eight-channel high-speed counter bank with a classic Wishbone slave,
  hardware frequency gate on inputs 0-3 and rate-limited event strobes.
  Assumes fast inputs synchronous to clock and a single-cycle Wishbone master.
*/
`timescale 1ns/1ps
`include "hscb_consts.svh"
module hscb_top #(
    parameter int unsigned GATE_CYCLES = `HSCB_GATE_CYCLES, // Frequency gate length
    parameter int unsigned EVENT_GAP   = `HSCB_EVENT_GAP    // Least event spacing
) (
    input  wire logic        clock,        // 50 MHz core clock
    input  wire logic        rst,          // Async reset, active high
    input  wire logic        ce,           // Clock enable, freezes all state
    input  wire logic [15:0] fast_in,      // Fast digital inputs
    input  wire logic        wb_cyc_i,     // Wishbone cycle
    input  wire logic        wb_stb_i,     // Wishbone strobe
    input  wire logic        wb_we_i,      // Wishbone write
    input  wire logic [7:0]  wb_adr_i,     // Wishbone byte address
    input  wire logic [31:0] wb_dat_i,     // Wishbone write data
    input  wire logic [3:0]  wb_sel_i,     // Wishbone byte lanes
    output logic      [31:0] wb_dat_o,     // Wishbone read data
    output logic             wb_ack_o,     // Wishbone acknowledge
    output logic             sel_valid_r,  // Selected counter valid
    output logic             sel_error_r,  // Selected counter error
    output logic [7:0]       event_r       // Event strobes of inputs 0-7
);
    hscb_pkg::hscb_cfg_type   cfg_r     [`HSCB_NUM_CH];
    hscb_pkg::hscb_count_type ring_lo_r [`HSCB_NUM_CH];
    hscb_pkg::hscb_count_type ring_hi_r [`HSCB_NUM_CH];
    hscb_pkg::hscb_count_type count_w   [`HSCB_NUM_CH];
    logic [15:0]              code_w    [`HSCB_NUM_CH];
    logic [31:0]              freq_r    [`HSCB_FREQ_INPUTS];
    logic [31:0]              edges_r   [`HSCB_FREQ_INPUTS];
    logic [31:0]              ev_gap_r  [`HSCB_EVENT_INPUTS];
    logic [`HSCB_NUM_CH-1:0]  err_w;
    logic [`HSCB_NUM_CH-1:0]  errclr_r;
    logic [15:0]              in_q;
    logic [15:0]              rise;
    logic [31:0]              gate_r;
    logic [2:0]               sel_r;
    logic                     req;
    logic                     wr;
    logic [15:0]              sel_code;
    logic                     sel_valid;

    // Byte-lane merge of a write into a register
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  lanes
    );
        lane_merge = old_v;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) lane_merge[8*i +: 8] = new_v[8*i +: 8];
        end
    endfunction

    // Frequency seen by a counter; inputs above 3 have no hardware gate
    function automatic logic [31:0] freq_of(input logic [2:0] ch, input logic quad);
        logic [3:0] idx;
        idx = quad ? {ch, 1'b0} : {1'b0, ch};
        if (idx < 4'h4) freq_of = freq_r[idx[1:0]];
        else            freq_of = 32'h00000000;
    endfunction

    // Ring bounds out of order on a ring channel
    function automatic logic ring_bad(input logic [2:0] ch);
        ring_bad = cfg_r[ch].ring && (ring_lo_r[ch] > ring_hi_r[ch]);
    endfunction

    assign req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr   = req & wb_we_i;
    assign rise = fast_in & ~in_q;

    // Channels
    for (genvar n = 0; n < `HSCB_NUM_CH; n++) begin : g_ch
        logic a_sel;
        // quadrature on 2n/2n+1, single-phase on n
        assign a_sel = cfg_r[n].quad ? fast_in[2*n] : fast_in[n];
        hscb_chan #(
            .SATURATE (n < `HSCB_SAT_CHANNELS)
        ) u_chan (
            .clock      (clock),
            .rst        (rst),
            .ce         (ce),
            .a_in       (a_sel),
            .b_in       (fast_in[2*n+1]),
            .trig_in    ((n < `HSCB_SAT_CHANNELS) ? fast_in[`HSCB_TRIG_BASE+n] : 1'b0),
            .cfg        (cfg_r[n]),
            .err_clear  (errclr_r[n]),
            .ring_lo    (ring_lo_r[n]),
            .ring_hi    (ring_hi_r[n]),
            .count_r    (count_w[n]),
            .err_r      (err_w[n]),
            .err_code_r (code_w[n])
        );
    end

    // Input history for edge detection
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            in_q <= 16'h0000;
        end else if (ce) begin
            in_q <= fast_in;
        end
    end

    // Counter select register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sel_r <= 3'h0;
        end else if (ce && wr && wb_adr_i == `HSCB_OFS_SELECT && wb_sel_i[0]) begin
            sel_r <= wb_dat_i[2:0];
        end
    end

    // Per-channel settings; commands act on the selected counter
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `HSCB_NUM_CH; i++) begin
                cfg_r[i]     <= '0;
                ring_lo_r[i] <= `HSCB_CNT_MIN;
                ring_hi_r[i] <= `HSCB_CNT_MAX;
            end
            errclr_r <= 8'h00;
        end else if (ce) begin
            errclr_r <= 8'h00;
            if (wr) begin
                if (wb_adr_i == `HSCB_OFS_CONFIG) begin
                    if (wb_sel_i[0]) begin
                        cfg_r[sel_r] <= hscb_pkg::hscb_cfg_type'(wb_dat_i[4:0]);
                    end
                    if (wb_sel_i[1]) begin
                        errclr_r[sel_r] <= wb_dat_i[`HSCB_CFG_ERRCLR];
                    end
                end else if (wb_adr_i == `HSCB_OFS_RING_LO) begin
                    ring_lo_r[sel_r] <= lane_merge(ring_lo_r[sel_r], wb_dat_i, wb_sel_i);
                end else if (wb_adr_i == `HSCB_OFS_RING_HI) begin
                    ring_hi_r[sel_r] <= lane_merge(ring_hi_r[sel_r], wb_dat_i, wb_sel_i);
                end
            end
        end
    end

    // gate counts rising edges per second
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gate_r <= 32'h00000000;
            for (int i = 0; i < `HSCB_FREQ_INPUTS; i++) begin
                edges_r[i] <= 32'h00000000;
                freq_r[i]  <= 32'h00000000;
            end
        end else if (ce) begin
            if (gate_r >= GATE_CYCLES - 1) begin
                gate_r <= 32'h00000000;
                for (int i = 0; i < `HSCB_FREQ_INPUTS; i++) begin
                    freq_r[i]  <= edges_r[i] + {31'h00000000, rise[i]};
                    edges_r[i] <= 32'h00000000;
                end
            end else begin
                gate_r <= gate_r + 32'h00000001;
                for (int i = 0; i < `HSCB_FREQ_INPUTS; i++) begin
                    edges_r[i] <= edges_r[i] + {31'h00000000, rise[i]};
                end
            end
        end
    end

    // event strobes, inputs 0-7, rate limited
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            event_r <= 8'h00;
            for (int i = 0; i < `HSCB_EVENT_INPUTS; i++) begin
                ev_gap_r[i] <= 32'h00000000;
            end
        end else if (ce) begin
            for (int i = 0; i < `HSCB_EVENT_INPUTS; i++) begin
                if (rise[i] && ev_gap_r[i] == 32'h00000000) begin
                    event_r[i]  <= 1'b1;
                    ev_gap_r[i] <= EVENT_GAP - 1;
                end else begin
                    event_r[i] <= 1'b0;
                    if (ev_gap_r[i] != 32'h00000000) begin
                        ev_gap_r[i] <= ev_gap_r[i] - 32'h00000001;
                    end
                end
            end
        end
    end

    // valid and error of the selected counter
    assign sel_code  = ring_bad(sel_r) ? `HSCB_ERR_RING : code_w[sel_r];
    assign sel_valid = cfg_r[sel_r].enable & ~err_w[sel_r] & ~ring_bad(sel_r);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sel_valid_r <= 1'b0;
            sel_error_r <= 1'b0;
        end else if (ce) begin
            sel_valid_r <= sel_valid;
            sel_error_r <= err_w[sel_r] | ring_bad(sel_r);
        end
    end

    // Wishbone slave: one-cycle answer, unmapped reads give zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce) begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                if (wb_adr_i == `HSCB_OFS_SELECT) begin
                    wb_dat_o <= {29'h00000000, sel_r};
                end else if (wb_adr_i == `HSCB_OFS_CONFIG) begin
                    wb_dat_o <= {27'h0000000, cfg_r[sel_r]};
                end else if (wb_adr_i == `HSCB_OFS_RING_LO) begin
                    wb_dat_o <= ring_lo_r[sel_r];
                end else if (wb_adr_i == `HSCB_OFS_RING_HI) begin
                    wb_dat_o <= ring_hi_r[sel_r];
                end else if (wb_adr_i == `HSCB_OFS_COUNT) begin
                    wb_dat_o <= count_w[sel_r];
                end else if (wb_adr_i == `HSCB_OFS_FREQ) begin
                    wb_dat_o <= freq_of(sel_r, cfg_r[sel_r].quad);
                end else if (wb_adr_i == `HSCB_OFS_STATUS) begin
                    wb_dat_o <= {sel_code, 14'h0000, sel_error_r, sel_valid_r};
                end else begin
                    wb_dat_o <= 32'h00000000;
                end
            end
        end
    end

    property p_ack_answer;
        @(posedge clock) disable iff (rst) (req && ce) |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack one cycle after request");

    property p_ack_pulse;
        @(posedge clock) disable iff (rst) (wb_ack_o && ce) |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held more than one cycle");

    property p_valid_en;
        @(posedge clock) disable iff (rst)
            (ce && !cfg_r[sel_r].enable) ##1 ce |-> !sel_valid_r;
    endproperty
    a_valid_en: assert property (p_valid_en) else $error("valid with counter disabled");

    property p_event_gap;
        @(posedge clock) disable iff (rst) event_r[0] |-> ##1 !event_r[0] [*8];
    endproperty
    a_event_gap: assert property (p_event_gap) else $error("event strobes too close");

    property p_no_event_high;
        @(posedge clock) disable iff (rst) (ce && !rise[0]) |=> !event_r[0];
    endproperty
    a_no_event_high: assert property (p_no_event_high) else $error("event without edge");
endmodule

// ### bench/hscb_src.sv
/*
  Pulse source and quadrature encoder model driving the sixteen fast inputs.
  Assumes start is a one-cycle request while busy is low.
*/
`timescale 1ns/1ps
module hscb_src #(
    parameter int HALF = 125 // Half period of 200 kHz at 50 MHz
) (
    input  wire logic       clock,   // Core clock
    input  wire logic       rst,     // Async reset
    input  wire logic       start,   // Begin a burst
    input  wire logic       quad,    // Quadrature burst on 2ch, 2ch+1
    input  wire logic       down,    // B leads A when set
    input  wire logic [2:0] ch,      // Counter channel
    input  wire logic [7:0] steps,   // Edges to make
    input  wire logic [3:0] trig,    // Trigger levels for inputs 8-11
    output logic            busy,    // Burst running
    output logic [15:0]     fast_in  // Fast input lines
);
    logic [15:0] pins_r;
    logic [7:0]  left_r;
    logic [1:0]  ph_r;
    logic [1:0]  ph_nxt;
    int          cnt_r;
    assign busy = (left_r != 8'h00);
    assign fast_in = pins_r | {4'h0, trig, 8'h00};
    assign ph_nxt = ph_r + (down ? 2'h3 : 2'h1);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pins_r <= 16'h0000;
            left_r <= 8'h00;
            ph_r   <= 2'h0;
            cnt_r  <= 0;
        end else if (start && !busy) begin
            left_r <= steps;
            cnt_r  <= HALF;
        end else if (busy) begin
            if (cnt_r > 1) begin
                cnt_r <= cnt_r - 1;
            end else begin
                cnt_r  <= HALF;
                left_r <= left_r - 8'h01;
                if (quad) begin
                    ph_r <= ph_nxt;
                    pins_r[{ch, 1'b0}] <= ph_nxt[0] ^ ph_nxt[1];
                    pins_r[{ch, 1'b1}] <= ph_nxt[1];
                end else begin
                    pins_r[{1'b0, ch}] <= ~pins_r[{1'b0, ch}];
                end
            end
        end
    end
endmodule

// ### bench/test_hscb_top.sv
/*
  Self-checking bench of the counter bank over Wishbone.
  Assumes the pulse source model and a 50 MHz clock.
*/
`timescale 1ns/1ps
`include "hscb_consts.svh"
module test_hscb_top;
    logic clock, rst, ce, cyc, stb, we, start, quad, down, busy, ack, vld, err;
    logic [7:0]  adr, steps, ev;
    logic [31:0] wdat, rdat, rd;
    logic [2:0]  ch;
    logic [3:0]  trig;
    logic [15:0] fin;
    int n_errors = 0;
    int comparisons = 0;
    int n_ev = 0;
    // Counts one-cycle event pulses of input 0
    always @(posedge clock) begin
        if (ev[0] === 1'b1) n_ev++;
    end
    hscb_src hscb_src_i (.clock(clock), .rst(rst), .start(start), .quad(quad), .down(down),
        .ch(ch), .steps(steps), .trig(trig), .busy(busy), .fast_in(fin));
    hscb_top #(.GATE_CYCLES(2000), .EVENT_GAP(10)) hscb_top_i (.clock(clock), .rst(rst),
        .ce(ce), .fast_in(fin), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sel_valid_r(vld), .sel_error_r(err), .event_r(ev));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic end_sim();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clock);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        if (n >= 20) chk(32'h0, 32'h1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic burst(input logic [2:0] c, input logic q, input logic dn, input int s);
        ch <= c;
        quad <= q;
        down <= dn;
        steps <= s[7:0];
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        @(posedge clock);
        while (busy === 1'b1) @(posedge clock);
        repeat (4) @(posedge clock);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd & mask, e);
    endtask
    initial begin
        {rst, ce, cyc, stb, we, start, quad, down} = 8'hC0;
        {adr, steps, wdat, ch, trig} = '0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd_chk(`HSCB_OFS_COUNT, 32'hFFFFFFFF, 32'h0);
        rd_chk(8'h1C, 32'hFFFFFFFF, 32'h0);
        wb(1'b1, `HSCB_OFS_SELECT, 32'h2);
        wb(1'b1, `HSCB_OFS_CONFIG, 32'h1);
        burst(3'h2, 1'b0, 1'b0, 6);
        rd_chk(`HSCB_OFS_COUNT, 32'hFFFFFFFF, 32'h3);
        rd_chk(`HSCB_OFS_STATUS, 32'h1, 32'h1);
        chk({31'h0, vld}, 32'h1);
        wb(1'b1, `HSCB_OFS_CONFIG, 32'h3);
        burst(3'h2, 1'b0, 1'b0, 4);
        rd_chk(`HSCB_OFS_COUNT, 32'hFFFFFFFF, 32'h1);
        wb(1'b1, `HSCB_OFS_CONFIG, 32'h0);
        burst(3'h2, 1'b0, 1'b0, 4);
        rd_chk(`HSCB_OFS_COUNT, 32'hFFFFFFFF, 32'h1);
        rd_chk(`HSCB_OFS_STATUS, 32'h1, 32'h0);
        wb(1'b1, `HSCB_OFS_SELECT, 32'h5);
        wb(1'b1, `HSCB_OFS_CONFIG, 32'h5);
        burst(3'h5, 1'b1, 1'b0, 8);
        rd_chk(`HSCB_OFS_COUNT, 32'hFFFFFFFF, 32'h8);
        wb(1'b1, `HSCB_OFS_CONFIG, 32'h7);
        burst(3'h5, 1'b1, 1'b1, 4);
        rd_chk(`HSCB_OFS_COUNT, 32'hFFFFFFFF, 32'h4);
        wb(1'b1, `HSCB_OFS_SELECT, 32'h0);
        wb(1'b1, `HSCB_OFS_CONFIG, 32'h11);
        burst(3'h0, 1'b0, 1'b0, 6);
        rd_chk(`HSCB_OFS_COUNT, 32'hFFFFFFFF, 32'h3);
        chk(n_ev, 32'h3);
        trig <= 4'h1;
        repeat (6) @(posedge clock);
        trig <= 4'h0;
        rd_chk(`HSCB_OFS_COUNT, 32'hFFFFFFFF, 32'h0);
        wb(1'b1, `HSCB_OFS_SELECT, 32'h3);
        wb(1'b1, `HSCB_OFS_RING_LO, 32'hFFFFFFFE);
        wb(1'b1, `HSCB_OFS_RING_HI, 32'h1);
        wb(1'b1, `HSCB_OFS_CONFIG, 32'h9);
        burst(3'h3, 1'b0, 1'b0, 6);
        rd_chk(`HSCB_OFS_COUNT, 32'hFFFFFFFF, 32'hFFFFFFFF);
        wb(1'b1, `HSCB_OFS_RING_LO, 32'h5);
        rd_chk(`HSCB_OFS_STATUS, 32'hFFFF0003, 32'h00020002);
        chk({31'h0, err}, 32'h1);
        wb(1'b1, `HSCB_OFS_SELECT, 32'h1);
        wb(1'b1, `HSCB_OFS_CONFIG, 32'h5);
        burst(3'h1, 1'b1, 1'b0, 40);
        rd_chk(`HSCB_OFS_FREQ, 32'hFFFFFFFF, 32'h4);
        rd_chk(`HSCB_OFS_COUNT, 32'hFFFFFFFF, 32'h28);
        wb(1'b1, `HSCB_OFS_SELECT, 32'h4);
        wb(1'b1, `HSCB_OFS_CONFIG, 32'h1);
        burst(3'h4, 1'b0, 1'b0, 4);
        wb(1'b1, `HSCB_OFS_CONFIG, 32'h1);
        ce <= 1'b0;
        burst(3'h4, 1'b0, 1'b0, 2);
        ce <= 1'b1;
        repeat (4100) @(posedge clock);
        rd_chk(`HSCB_OFS_FREQ, 32'hFFFFFFFF, 32'h0);
        rd_chk(`HSCB_OFS_COUNT, 32'hFFFFFFFF, 32'h2);
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        end_sim();
    end
endmodule
